// ---- hdl/irq_pkg.sv ----
`default_nettype none
package irq_pkg;
    localparam int ADDR_W = 8;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] EPC_OFS  = 8'h00;
    localparam logic [ADDR_W-1:0] EIC_OFS  = 8'h04;
    localparam logic [ADDR_W-1:0] PF1_OFS  = 8'h08;
    localparam logic [ADDR_W-1:0] PF2_OFS  = 8'h0C;
    localparam logic [ADDR_W-1:0] STAT_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] MASK_OFS = 8'h14;
    // Reset values
    localparam logic [7:0] EPC_RST = 8'hFF;
    localparam logic [7:0] EIC_RST = 8'hC0;
    localparam logic [7:0] PF_RST  = 8'h00;
    // edge_priority_control fields
    localparam int PULLUP_DIS_BIT = 7;
    localparam int EDGE_SEL0_BIT  = 6;
    localparam int T0_PRIO_BIT    = 2;
    localparam int EXT3_PRIO_BIT  = 1;
    localparam int PCHG_PRIO_BIT  = 0;
    // external_irq_control fields
    localparam int EXT2_PRIO_BIT  = 7;
    localparam int EXT1_PRIO_BIT  = 6;
    localparam int EXT1_EN_BIT    = 3;
    localparam int EXT1_FLAG_BIT  = 0;
    // peripheral flag fields
    localparam int RX_FLAG_BIT    = 5;
    localparam int TX_FLAG_BIT    = 4;
    localparam int PF2_GAP_BIT    = 6;
    // Status / mask layout
    localparam int STAT_W = 6;
    localparam int ST_PF1_BIT = 4;
    localparam int ST_PF2_BIT = 5;
    // Vectors
    localparam logic [15:0] VEC_HIGH = 16'h0008;
    localparam logic [15:0] VEC_LOW  = 16'h0018;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic slave_port;
        logic adc_done;
        logic sync_one;
        logic timer_one_gate;
        logic timer_two_match;
        logic timer_one_ovf;
    } pf1_evt_t;

    typedef struct packed {
        logic osc_fail;
        logic sync_two;
        logic bus_collision_two;
        logic bus_collision_one;
        logic voltage_detect;
        logic timer_three_ovf;
        logic timer_three_gate;
    } pf2_evt_t;
endpackage
`default_nettype wire

// ---- hdl/irq_edge_priority_flag_regs.sv ----
// Operation
// - Pull-up disable bit forces all pull-ups off
// - Edge select bits choose rising or falling
// - Priority bits: one high, zero low
// - Enable bits gate external interrupt requests
// - External flags set on event, software clears
// - Flags set regardless of any enable
// - Receive flag read-only, mirrors buffer full
// - Transmit flag read-only, mirrors buffer empty
// - Sync port flags set on completion
// - Timer three overflow flag is sticky
// - Timer three gate flag is sticky
// - Oscillator fail flag set on clock switchover
// - Two bus collision flags, software cleared
// - Voltage detect flag set on low voltage
// - Unused bit reads zero, ignores writes
// - Priority bits act only when feature enabled
// - High vectors to 0008h, low 0018h
`default_nettype none
module irq_edge_priority_flag_regs
    import irq_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // External interrupt pins and port B
    input  wire logic [3:0]        ext_irq_pin,
    input  wire logic [7:0]        port_b_latch,
    output logic [7:0]             port_b_pullup_en,
    output logic                   ext_zero_event,
    // Peripheral sources
    input  wire pf1_evt_t          pf1_evt,
    input  wire pf2_evt_t          pf2_evt,
    input  wire logic              serial_one_rx_full,
    input  wire logic              serial_one_tx_empty,
    // Enables, priorities and timer zero / port change requests held elsewhere
    input  wire logic              priority_feature_enable,
    input  wire logic [7:0]        pie_one,
    input  wire logic [7:0]        pie_two,
    input  wire logic [7:0]        ipr_one,
    input  wire logic [7:0]        ipr_two,
    input  wire logic              timer_zero_req,
    input  wire logic              port_change_req,
    // To core vectoring
    output logic                   irq_request,
    output logic                   irq_high,
    output logic [15:0]            vector_addr,
    // Interrupt line
    output logic                   irq
);

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
        unique case (a)
            EPC_OFS:  reg_index = 3'd1;
            EIC_OFS:  reg_index = 3'd2;
            PF1_OFS:  reg_index = 3'd3;
            PF2_OFS:  reg_index = 3'd4;
            STAT_OFS: reg_index = 3'd5;
            MASK_OFS: reg_index = 3'd6;
            default:  reg_index = 3'd0;
        endcase
    endfunction

    // Register state first: the edge select and read mux below both read it
    logic [7:0]        epc;
    logic [7:0]        eic;
    logic [7:0]        pf1;
    logic [7:0]        pf2;
    logic [STAT_W-1:0] status;
    logic [STAT_W-1:0] mask;

    // ---------------- Pin synchronisers ----------------
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    logic [3:0] sync_prev;
    logic [3:0] edge_hit;
    logic [3:0] edge_sel;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync_a    <= 4'h0;
            sync_b    <= 4'h0;
            sync_prev <= 4'h0;
        end else begin
            sync_a    <= ext_irq_pin;
            sync_b    <= sync_a;
            sync_prev <= sync_b;
        end
    end

    // Edge select for pin i sits at bit (6 - i)
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            edge_sel[i] = epc[EDGE_SEL0_BIT - i];
            edge_hit[i] = edge_sel[i] ? (sync_b[i] & ~sync_prev[i])
                                      : (~sync_b[i] & sync_prev[i]);
        end
    end

    // ---------------- AXI4-Lite slave ----------------
    logic              aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_held;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              next_aw_held;
    logic [ADDR_W-1:0] next_aw_addr;
    logic              next_w_held;
    logic [31:0]       next_w_data;
    logic [3:0]        next_w_strb;
    logic              next_bvalid;
    logic [1:0]        next_bresp;
    logic              next_rvalid;
    logic [31:0]       next_rdata;
    logic [1:0]        next_rresp;
    logic              have_aw;
    logic              have_w;
    logic              wr_fire;
    logic [2:0]        wr_sel;
    logic [7:0]        wr_byte;
    logic [2:0]        rd_sel;

    assign awready = ~aw_held & ~bvalid;
    assign wready  = ~w_held & ~bvalid;
    assign arready = ~rvalid;

    always_comb begin
        have_aw      = aw_held | (awvalid & awready);
        have_w       = w_held | (wvalid & wready);
        wr_fire      = have_aw & have_w & ~bvalid;
        wr_sel       = reg_index(aw_held ? aw_addr : awaddr);
        wr_byte      = w_held ? w_data[7:0] : wdata[7:0];
        if (!(w_held ? w_strb[0] : wstrb[0])) begin
            // Only lane 0 carries register bits
            wr_sel = (wr_sel == 3'd0) ? 3'd0 : 3'd7;
        end
        rd_sel       = reg_index(araddr);
        next_aw_held = have_aw & ~wr_fire;
        next_aw_addr = (awvalid & awready) ? awaddr : aw_addr;
        next_w_held  = have_w & ~wr_fire;
        next_w_data  = (wvalid & wready) ? wdata : w_data;
        next_w_strb  = (wvalid & wready) ? wstrb : w_strb;
        next_bvalid  = bvalid & ~bready;
        next_bresp   = bresp;
        if (wr_fire) begin
            next_bvalid = 1'b1;
            next_bresp  = (wr_sel == 3'd0) ? RESP_SLVERR : RESP_OKAY;
        end
        next_rvalid = rvalid & ~rready;
        next_rdata  = rdata;
        next_rresp  = rresp;
        if (arvalid & arready) begin
            next_rvalid = 1'b1;
            next_rresp  = (rd_sel == 3'd0) ? RESP_SLVERR : RESP_OKAY;
            unique case (rd_sel)
                3'd1:    next_rdata = {24'h00_0000, epc};
                3'd2:    next_rdata = {24'h00_0000, eic};
                3'd3:    next_rdata = {24'h00_0000, pf1};
                3'd4:    next_rdata = {24'h00_0000, pf2};
                3'd5:    next_rdata = {26'h000_0000, status};
                3'd6:    next_rdata = {26'h000_0000, mask};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            w_held  <= 1'b0;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= RESP_OKAY;
        end else begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held  <= next_w_held;
            w_data  <= next_w_data;
            w_strb  <= next_w_strb;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            rvalid  <= next_rvalid;
            rdata   <= next_rdata;
            rresp   <= next_rresp;
        end
    end

    // ---------------- Registers and flags ----------------
    logic [7:0]        next_epc;
    logic [7:0]        next_eic;
    logic [7:0]        next_pf1;
    logic [7:0]        next_pf2;
    logic [STAT_W-1:0] next_status;
    logic [STAT_W-1:0] next_mask;
    logic [7:0]        pf1_set;
    logic [7:0]        pf2_set;
    logic [STAT_W-1:0] stat_set;

    always_comb begin
        pf1_set = {pf1_evt.slave_port, pf1_evt.adc_done, 2'b00,
                   pf1_evt.sync_one, pf1_evt.timer_one_gate,
                   pf1_evt.timer_two_match, pf1_evt.timer_one_ovf};
        pf2_set = {pf2_evt.osc_fail, 1'b0, pf2_evt.sync_two,
                   pf2_evt.bus_collision_two, pf2_evt.bus_collision_one,
                   pf2_evt.voltage_detect, pf2_evt.timer_three_ovf,
                   pf2_evt.timer_three_gate};
        stat_set = {|pf2_set, |pf1_set, edge_hit};
    end

    always_comb begin
        next_epc    = epc;
        next_eic    = eic;
        next_pf1    = pf1;
        next_pf2    = pf2;
        next_status = status;
        next_mask   = mask;
        if (wr_fire) begin
            unique case (wr_sel)
                3'd1:    next_epc = wr_byte;
                3'd2:    next_eic = wr_byte;
                3'd3:    next_pf1 = wr_byte;
                3'd4:    next_pf2 = wr_byte;
                3'd5:    next_status = status & ~wr_byte[STAT_W-1:0];
                3'd6:    next_mask = wr_byte[STAT_W-1:0];
                default: next_mask = mask;
            endcase
        end
        // Hardware sets are applied last so an event beats a same-cycle clear
        next_eic[EXT1_FLAG_BIT +: 3] = next_eic[EXT1_FLAG_BIT +: 3] | edge_hit[3:1];
        next_pf1    = next_pf1 | pf1_set;
        next_pf2    = next_pf2 | pf2_set;
        next_pf1[RX_FLAG_BIT] = serial_one_rx_full;
        next_pf1[TX_FLAG_BIT] = serial_one_tx_empty;
        next_pf2[PF2_GAP_BIT] = 1'b0;
        next_status = next_status | stat_set;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            epc    <= EPC_RST;
            eic    <= EIC_RST;
            pf1    <= PF_RST;
            pf2    <= PF_RST;
            status <= '0;
            mask   <= '0;
        end else begin
            epc    <= next_epc;
            eic    <= next_eic;
            pf1    <= next_pf1;
            pf2    <= next_pf2;
            status <= next_status;
            mask   <= next_mask;
        end
    end

    // ---------------- Request and vector ----------------
    logic [4:0]  src_req;
    logic [4:0]  src_prio;
    logic        any_hi;
    logic        any_lo;
    logic        next_irq_request;
    logic        next_irq_high;
    logic [15:0] next_vector_addr;
    logic [7:0]  next_pullup;
    logic        next_irq;
    logic        next_ext_zero;

    always_comb begin
        // ext1, ext2, ext3, timer zero, port change
        src_req  = {port_change_req, timer_zero_req,
                    eic[EXT1_FLAG_BIT +: 3] & eic[EXT1_EN_BIT +: 3]};
        src_prio = {epc[PCHG_PRIO_BIT], epc[T0_PRIO_BIT], epc[EXT3_PRIO_BIT],
                    eic[EXT2_PRIO_BIT], eic[EXT1_PRIO_BIT]};
        any_hi = |(src_req & src_prio) | |(pf1 & pie_one & ipr_one)
               | |(pf2 & pie_two & ipr_two);
        any_lo = |(src_req & ~src_prio) | |(pf1 & pie_one & ~ipr_one)
               | |(pf2 & pie_two & ~ipr_two);
        next_irq_request = any_hi | any_lo;
        if (!priority_feature_enable) begin
            // Compatibility mode: priority bits ignored
            next_irq_high    = 1'b0;
            next_vector_addr = VEC_HIGH;
        end else begin
            next_irq_high    = any_hi;
            next_vector_addr = any_hi ? VEC_HIGH : (any_lo ? VEC_LOW : VEC_HIGH);
        end
        next_pullup   = epc[PULLUP_DIS_BIT] ? 8'h00 : port_b_latch;
        next_irq      = |(status & mask);
        next_ext_zero = edge_hit[0];
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_request      <= 1'b0;
            irq_high         <= 1'b0;
            vector_addr      <= VEC_HIGH;
            port_b_pullup_en <= 8'h00;
            irq              <= 1'b0;
            ext_zero_event   <= 1'b0;
        end else begin
            irq_request      <= next_irq_request;
            irq_high         <= next_irq_high;
            vector_addr      <= next_vector_addr;
            port_b_pullup_en <= next_pullup;
            irq              <= next_irq;
            ext_zero_event   <= next_ext_zero;
        end
    end

    // ---------------- Assertions ----------------
    a_pullup_off: assert property (epc[PULLUP_DIS_BIT] |=> port_b_pullup_en == 8'h00)
        else $error("pull-ups not off while disabled");
    a_pullup_follow: assert property (!epc[PULLUP_DIS_BIT]
        |=> port_b_pullup_en == $past(port_b_latch))
        else $error("pull-ups do not follow port latch");
    a_rising_sets: assert property (edge_sel[1] && sync_b[1] && !sync_prev[1]
        |=> eic[EXT1_FLAG_BIT])
        else $error("rising edge did not set ext one flag");
    a_edge_single: assert property (edge_hit[2] |=> !edge_hit[2])
        else $error("edge event longer than one cycle");
    a_pin_sync: assert property ($rose(ext_irq_pin[3]) && epc[EDGE_SEL0_BIT - 3]
        ##1 ext_irq_pin[3] ##1 ext_irq_pin[3] |-> eic[EXT1_FLAG_BIT + 2] || edge_hit[3])
        else $error("ext three edge not seen after two stages");
    a_ext_mask: assert property (!eic[EXT1_EN_BIT] && !timer_zero_req && !port_change_req
        && eic[EXT1_EN_BIT +: 3] == 3'b000 && pie_one == 8'h00 && pie_two == 8'h00
        |=> !irq_request)
        else $error("request raised with every source masked");
    a_flag_poll: assert property (pf1_evt.adc_done |=> pf1[6])
        else $error("flag not set while enables clear");
    a_rx_mirror: assert property (##1 pf1[RX_FLAG_BIT] == $past(serial_one_rx_full))
        else $error("receive flag does not mirror buffer state");
    a_tx_mirror: assert property (##1 pf1[TX_FLAG_BIT] == $past(serial_one_tx_empty))
        else $error("transmit flag does not mirror buffer state");
    a_gap_zero: assert property (pf2[PF2_GAP_BIT] == 1'b0)
        else $error("unimplemented bit reads one");
    a_osc_sticky: assert property (pf2[7] && !(wr_fire && wr_sel == 3'd4)
        |=> pf2[7])
        else $error("oscillator fail flag dropped without a write");
    a_compat_vec: assert property (!priority_feature_enable && next_irq_request
        |=> vector_addr == VEC_HIGH && !irq_high)
        else $error("compatibility mode vector wrong");
    a_low_vec: assert property (priority_feature_enable && !any_hi && any_lo
        |=> vector_addr == VEC_LOW)
        else $error("low priority vector wrong");
    a_set_wins: assert property (edge_hit[1] && wr_fire && wr_sel == 3'd2
        |=> eic[EXT1_FLAG_BIT])
        else $error("event lost to same-cycle clear");

endmodule
`default_nettype wire

// ---- tb/periph_src_model.sv ----
`default_nettype none
module periph_src_model
    import irq_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Commands from the bench
    input  wire logic       go_one,
    input  wire logic       go_two,
    input  wire logic [2:0] evt_idx,
    input  wire logic [3:0] uart_cmd,
    // Towards the block
    output var pf1_evt_t    pf1_evt,
    output var pf2_evt_t    pf2_evt,
    output logic            rx_full,
    output logic            tx_empty
);
    timeunit 1ns;
    timeprecision 1ns;

    // A source pulses for exactly one cycle; the block must hold the flag itself
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pf1_evt  <= '0;
            pf2_evt  <= '0;
            rx_full  <= 1'b0;
            tx_empty <= 1'b0;
        end else begin
            pf1_evt <= go_one ? pf1_evt_t'(6'd1 << evt_idx) : '0;
            pf2_evt <= go_two ? pf2_evt_t'(7'd1 << evt_idx) : '0;
            // Command bits: 0 byte received, 1 buffer read, 2 buffer written, 3 byte sent
            if (uart_cmd[0]) begin
                rx_full <= 1'b1;
            end else if (uart_cmd[1]) begin
                rx_full <= 1'b0;
            end
            if (uart_cmd[2]) begin
                tx_empty <= 1'b0;
            end else if (uart_cmd[3]) begin
                tx_empty <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/irq_edge_priority_flag_regs_tb_top.sv ----
`default_nettype none
module irq_edge_priority_flag_regs_tb_top
    import irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        core_clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, ext_zero_event;
    logic        rx_full, tx_empty, priority_feature_enable, irq_request, irq_high, irq;
    logic        go_one, go_two, timer_zero_req, port_change_req;
    logic [1:0]  bresp, rresp;
    logic [2:0]  evt_idx;
    logic [3:0]  wstrb, ext_irq_pin, uart_cmd;
    logic [7:0]  awaddr, araddr, port_b_latch, port_b_pullup_en, pie_two;
    logic [15:0] vector_addr;
    logic [31:0] wdata, rdata;
    pf1_evt_t    pf1_evt;
    pf2_evt_t    pf2_evt;
    int          err_total, num_checks;
    int          zero_hits = 0;

    irq_edge_priority_flag_regs u_dut (
        .core_clk(core_clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .ext_irq_pin(ext_irq_pin),
        .port_b_latch(port_b_latch), .port_b_pullup_en(port_b_pullup_en),
        .ext_zero_event(ext_zero_event), .pf1_evt(pf1_evt), .pf2_evt(pf2_evt),
        .serial_one_rx_full(rx_full), .serial_one_tx_empty(tx_empty),
        .priority_feature_enable(priority_feature_enable), .pie_one(8'h00),
        .pie_two(pie_two), .ipr_one(8'h00), .ipr_two(8'h00), .timer_zero_req(timer_zero_req),
        .port_change_req(port_change_req), .irq_request(irq_request), .irq_high(irq_high),
        .vector_addr(vector_addr), .irq(irq)
    );

    periph_src_model u_src (
        .core_clk(core_clk), .rst(rst), .go_one(go_one), .go_two(go_two),
        .evt_idx(evt_idx), .uart_cmd(uart_cmd), .pf1_evt(pf1_evt), .pf2_evt(pf2_evt),
        .rx_full(rx_full), .tx_empty(tx_empty)
    );

    always #50 core_clk = ~core_clk;

    // Pin 0 has no flag in the external control register, so its one-cycle pulses are counted
    always @(posedge core_clk) begin
        if (ext_zero_event === 1'b1) begin
            zero_hits++;
        end
    end

    task automatic finish_test;
        if (err_total == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
    endtask

    // Readies are combinational, so they are looked at mid-cycle to avoid edge races
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = RESP_OKAY);
        int n;
        logic ta, tw, tb;
        logic [1:0] rsp;
        @(posedge core_clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        n  = 0;
        tb = 1'b0;
        while (!tb && n < 50) begin
            @(negedge core_clk);
            ta  = awvalid && awready;
            tw  = wvalid && wready;
            tb  = bvalid;
            rsp = bresp;
            @(posedge core_clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            n++;
        end
        chk(32'(tb), 32'h0000_0001);
        chk(32'(rsp), 32'(er));
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input logic [1:0] er = RESP_OKAY);
        int n;
        logic ta, tr;
        logic [31:0] d;
        logic [1:0] rsp;
        @(posedge core_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        n  = 0;
        tr = 1'b0;
        while (!tr && n < 50) begin
            @(negedge core_clk);
            ta  = arvalid && arready;
            tr  = rvalid;
            d   = rdata;
            rsp = rresp;
            @(posedge core_clk);
            if (ta) arvalid <= 1'b0;
            n++;
        end
        chk(32'(tr), 32'h0000_0001);
        chk(d, exp);
        chk(32'(rsp), 32'(er));
    endtask

    task automatic fire(input logic two, input logic [2:0] idx);
        @(posedge core_clk);
        go_two  <= two;
        go_one  <= !two;
        evt_idx <= idx;
        @(posedge core_clk);
        go_one <= 1'b0;
        go_two <= 1'b0;
    endtask

    task automatic uart(input logic [3:0] c);
        @(posedge core_clk);
        uart_cmd <= c;
        @(posedge core_clk);
        uart_cmd <= 4'h0;
    endtask

    task automatic chk_vec(input logic req, input logic hi, input logic [15:0] v);
        cyc(2);
        chk(32'(irq_request), 32'(req));
        chk(32'(irq_high), 32'(hi));
        chk(32'(vector_addr), 32'(v));
    endtask

    initial begin
        #500000;
        err_total++;
        finish_test;
    end

    initial begin
        int b;
        core_clk = 1'b0;
        rst = 1'b1;
        {awvalid, wvalid, arvalid, go_one, go_two, priority_feature_enable} = '0;
        {bready, rready} = 2'b11;
        {timer_zero_req, port_change_req} = 2'b00;
        {awaddr, araddr, wdata, evt_idx, ext_irq_pin, uart_cmd, pie_two} = '0;
        wstrb = 4'hF;
        port_b_latch = 8'hA5;
        err_total = 0;
        num_checks = 0;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        rd(EPC_OFS, 32'h0000_00FF);
        rd(EIC_OFS, 32'h0000_00C0);
        rd(PF1_OFS, 32'h0000_0000);
        rd(PF2_OFS, 32'h0000_0000);
        rd(STAT_OFS, 32'h0000_0000);
        rd(MASK_OFS, 32'h0000_0000);
        chk(32'(port_b_pullup_en), 32'h0000_0000);
        wr(EPC_OFS, 32'h0000_007A);
        rd(EPC_OFS, 32'h0000_007A);
        wr(EPC_OFS, 32'h0000_007F);
        cyc(2);
        chk(32'(port_b_pullup_en), 32'h0000_00A5);
        // Each pin: rising edge with select 1, then falling edge with select 0
        for (int i = 0; i < 4; i++) begin
            b = (i == 0) ? 32'h0000_00C0 : 32'h0000_00C0 | (1 << (i - 1));
            ext_irq_pin[i] <= 1'b1;
            cyc(5);
            rd(STAT_OFS, 32'(1 << i));
            rd(EIC_OFS, 32'(b));
            wr(STAT_OFS, 32'(1 << i));
            wr(EIC_OFS, 32'h0000_00C0);
            wr(EPC_OFS, 32'h0000_007F & ~32'(1 << (6 - i)));
            ext_irq_pin[i] <= 1'b0;
            cyc(5);
            rd(STAT_OFS, 32'(1 << i));
            rd(EIC_OFS, 32'(b));
            wr(STAT_OFS, 32'(1 << i));
            wr(EIC_OFS, 32'h0000_00C0);
            wr(EPC_OFS, 32'h0000_007F);
        end
        chk(32'(zero_hits), 32'h0000_0002);
        // Software clear lands in the very cycle the pin 1 edge is seen
        ext_irq_pin[1] <= 1'b1;
        cyc(1);
        wr(EIC_OFS, 32'h0000_00C0);
        rd(EIC_OFS, 32'h0000_00C1);
        wr(STAT_OFS, 32'h0000_0002);
        wr(EIC_OFS, 32'h0000_00C0);
        // Every peripheral source, flag register one then two
        for (int g = 0; g < 2; g++) begin
            for (int i = 0; i < 6 + g; i++) begin
                b = g ? ((i == 6) ? 7 : i) : ((i < 4) ? i : i + 2);
                fire(g[0], 3'(i));
                cyc(3);
                rd(g ? PF2_OFS : PF1_OFS, 32'(1 << b));
                rd(STAT_OFS, g ? 32'h0000_0020 : 32'h0000_0010);
                wr(g ? PF2_OFS : PF1_OFS, 32'h0000_0000);
                wr(STAT_OFS, 32'h0000_0030);
                rd(g ? PF2_OFS : PF1_OFS, 32'h0000_0000);
            end
        end
        uart(4'b0001);
        cyc(2);
        wr(PF1_OFS, 32'h0000_0000);
        rd(PF1_OFS, 32'h0000_0020);
        uart(4'b1010);
        cyc(2);
        rd(PF1_OFS, 32'h0000_0010);
        wr(PF1_OFS, 32'h0000_00FF);
        rd(PF1_OFS, 32'h0000_00DF);
        uart(4'b0100);
        cyc(2);
        rd(PF1_OFS, 32'h0000_00CF);
        wr(PF1_OFS, 32'h0000_0000);
        wr(PF2_OFS, 32'h0000_00FF);
        rd(PF2_OFS, 32'h0000_00BF);
        wr(PF2_OFS, 32'h0000_0000);
        wr(STAT_OFS, 32'h0000_003F);
        rd(STAT_OFS, 32'h0000_0000);
        // Interrupt line: raise, mask, unmask, clear
        wr(MASK_OFS, 32'h0000_0020);
        rd(MASK_OFS, 32'h0000_0020);
        fire(1'b1, 3'd1);
        cyc(3);
        chk(32'(irq), 32'h0000_0001);
        wr(MASK_OFS, 32'h0000_0000);
        cyc(2);
        chk(32'(irq), 32'h0000_0000);
        wr(MASK_OFS, 32'h0000_0020);
        cyc(2);
        chk(32'(irq), 32'h0000_0001);
        pie_two <= 8'h02;
        chk_vec(1'b1, 1'b0, VEC_HIGH);
        priority_feature_enable <= 1'b1;
        chk_vec(1'b1, 1'b0, VEC_LOW);
        wr(STAT_OFS, 32'h0000_0020);
        cyc(2);
        chk(32'(irq), 32'h0000_0000);
        wr(PF2_OFS, 32'h0000_0000);
        pie_two <= 8'h00;
        chk_vec(1'b0, 1'b0, VEC_HIGH);
        // External request through its own enable and priority
        wr(EIC_OFS, 32'h0000_00C9);
        chk_vec(1'b1, 1'b1, VEC_HIGH);
        wr(EIC_OFS, 32'h0000_0089);
        chk_vec(1'b1, 1'b0, VEC_LOW);
        priority_feature_enable <= 1'b0;
        chk_vec(1'b1, 1'b0, VEC_HIGH);
        wr(EIC_OFS, 32'h0000_00C1);
        chk_vec(1'b0, 1'b0, VEC_HIGH);
        rd(EIC_OFS, 32'h0000_00C1);
        // Timer zero and port change requests through their priority bits
        priority_feature_enable <= 1'b1;
        timer_zero_req <= 1'b1;
        chk_vec(1'b1, 1'b1, VEC_HIGH);
        wr(EPC_OFS, 32'h0000_007B);
        chk_vec(1'b1, 1'b0, VEC_LOW);
        {timer_zero_req, port_change_req} <= 2'b01;
        chk_vec(1'b1, 1'b1, VEC_HIGH);
        wr(EPC_OFS, 32'h0000_007A);
        chk_vec(1'b1, 1'b0, VEC_LOW);
        {port_change_req, priority_feature_enable} <= 2'b00;
        chk_vec(1'b0, 1'b0, VEC_HIGH);
        // Lane 0 strobe low: accepted but no register changes
        wstrb <= 4'hE;
        wr(EIC_OFS, 32'h0000_0000);
        wstrb <= 4'hF;
        rd(EIC_OFS, 32'h0000_00C1);
        wr(8'h18, 32'h0000_00FF, RESP_SLVERR);
        rd(8'h18, 32'h0000_0000, RESP_SLVERR);
        finish_test;
    end
endmodule
`default_nettype wire
